// *** pkg/udc_pkg.sv ***
/*
  Shared constants and types of the synchronous 4-bit up/down counter.
  Assumes one clock domain and a 32-bit classic Wishbone register port.
*/
package udc_pkg;

  // ----------------------------------------------------------------
  // Counter geometry
  // ----------------------------------------------------------------
  localparam int         CNT_W   = 4;
  localparam logic [3:0] CNT_MAX = 4'hF;
  localparam logic [3:0] CNT_MIN = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int         WB_AW = 8;
  localparam int         WB_DW = 32;
  localparam int         WB_SW = 4;

  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL   = 8'h04;
  localparam logic [7:0] REG_WRAPS  = 8'h08;

  localparam int         STAT_COUNT_LSB  = 0;
  localparam int         STAT_CARRY_BIT  = 4;
  localparam int         STAT_UP_BIT     = 5;
  localparam int         STAT_FREEZE_BIT = 8;
  localparam int         CTRL_FREEZE_BIT = 0;
  localparam int         WRAP_W          = 16;

  localparam logic              CTRL_FREEZE_RST = 1'b0;
  localparam logic [WRAP_W-1:0] WRAPS_RST       = 16'h0000;
  localparam logic [WRAP_W-1:0] WRAPS_ONE       = 16'h0001;
  localparam logic [WB_DW-1:0]  RD_ZERO         = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Operation chosen at each clock edge
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    UDC_OP_HOLD = 2'b00,
    UDC_OP_LOAD = 2'b01,
    UDC_OP_UP   = 2'b10,
    UDC_OP_DOWN = 2'b11
  } udc_op_t;

endpackage

// *** design/udc_next.sv ***
/*
  Next-value logic of the counter: picks load, count up, count down or hold.
  Assumes all inputs are sampled by the caller on the same rising clock edge.
*/
`timescale 1ns/1ns
module udc_next (
  input  wire logic                       load_n_i,
  input  wire logic                       count_enable_parallel_n_i,
  input  wire logic                       trickle_enable_n_i,
  input  wire logic                       up_i,
  input  wire logic                       freeze_i,
  input  wire logic [udc_pkg::CNT_W-1:0]  data_i,
  input  wire logic [udc_pkg::CNT_W-1:0]  count_i,
  output udc_pkg::udc_op_t                op_o,
  output logic      [udc_pkg::CNT_W-1:0]  next_count_o
);

  wire logic                      do_load;
  wire logic                      do_count;
  wire logic [udc_pkg::CNT_W-1:0] count_inc;
  wire logic [udc_pkg::CNT_W-1:0] count_dec;

  // Load wins over counting and is not gated by the enables
  assign do_load   = ~load_n_i;
  assign do_count  = ~count_enable_parallel_n_i & ~trickle_enable_n_i
                     & ~freeze_i;
  // Four-bit arithmetic wraps modulo sixteen by itself
  assign count_inc = count_i + udc_pkg::CNT_ONE;
  assign count_dec = count_i - udc_pkg::CNT_ONE;

  assign op_o = do_load  ? udc_pkg::UDC_OP_LOAD :
                !do_count ? udc_pkg::UDC_OP_HOLD :
                up_i     ? udc_pkg::UDC_OP_UP   : udc_pkg::UDC_OP_DOWN;

  always_comb begin
    unique case (op_o)
      udc_pkg::UDC_OP_LOAD: next_count_o = data_i;
      udc_pkg::UDC_OP_UP:   next_count_o = count_inc;
      udc_pkg::UDC_OP_DOWN: next_count_o = count_dec;
      udc_pkg::UDC_OP_HOLD: next_count_o = count_i;
    endcase
  end

endmodule

// *** design/udc_carry.sv ***
/*
  Ripple-carry decode: low at the terminal count in the present direction while the trickle enable is active.
  Assumes the caller feeds the stored count; no clock is involved here.
*/
`timescale 1ns/1ns
module udc_carry (
  input  wire logic                       trickle_enable_n_i,
  input  wire logic                       up_i,
  input  wire logic [udc_pkg::CNT_W-1:0]  count_i,
  output logic                            terminal_o,
  output logic                            carry_out_n_o
);

  wire logic at_max;
  wire logic at_min;

  assign at_max     = (count_i == udc_pkg::CNT_MAX);
  assign at_min     = (count_i == udc_pkg::CNT_MIN);
  assign terminal_o = up_i ? at_max : at_min;
  // Only the trickle enable gates the carry, so a stage held by its
  // parallel enable still passes the carry on to the next stage
  assign carry_out_n_o = ~(terminal_o & ~trickle_enable_n_i);

endmodule

// *** design/udc_counter.sv ***
/*
  Top of the synchronous presettable 4-bit up/down counter with a small
  classic Wishbone register port for freeze control and status readback.
  Assumes the counter pins are driven by logic on clk_i, so they are used
  without synchronisers, and that the register master follows classic
  single-cycle Wishbone.
*/
`timescale 1ns/1ns
module udc_counter (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         load_n_i,
  input  wire logic [udc_pkg::CNT_W-1:0]    data_i,
  input  wire logic                         count_enable_parallel_n_i,
  input  wire logic                         trickle_enable_n_i,
  input  wire logic                         up_i,
  output logic      [udc_pkg::CNT_W-1:0]    count_o,
  output logic                              carry_out_n_o,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [udc_pkg::WB_AW-1:0]    wb_adr_i,
  input  wire logic [udc_pkg::WB_SW-1:0]    wb_sel_i,
  input  wire logic [udc_pkg::WB_DW-1:0]    wb_dat_i,
  output logic      [udc_pkg::WB_DW-1:0]    wb_dat_o,
  output logic                              wb_ack_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [udc_pkg::CNT_W-1:0]   count;
  logic                        freeze;
  logic [udc_pkg::WRAP_W-1:0]  wraps;
  logic                        ack;
  logic [udc_pkg::WB_DW-1:0]   rd_data_q;

  udc_pkg::udc_op_t            op;
  wire logic [udc_pkg::CNT_W-1:0] next_count;
  wire logic                   terminal;
  wire logic                   carry_n;

  wire logic                   wb_req;
  wire logic                   wb_wr_commit;
  wire logic                   hit_status;
  wire logic                   hit_ctrl;
  wire logic                   hit_wraps;
  wire logic                   wr_ctrl;
  wire logic                   wr_freeze_val;
  wire logic                   clr_wraps;
  wire logic                   wrap_event;
  wire logic [udc_pkg::WB_DW-1:0] status_word;
  wire logic [udc_pkg::WB_DW-1:0] ctrl_word;
  wire logic [udc_pkg::WB_DW-1:0] wraps_word;
  wire logic [udc_pkg::WB_DW-1:0] rd_data;
  logic [udc_pkg::WRAP_W-1:0]  next_wraps;

  // ----------------------------------------------------------------
  // Counter core
  // ----------------------------------------------------------------
  udc_next u_next (
    .load_n_i                  (load_n_i),
    .count_enable_parallel_n_i (count_enable_parallel_n_i),
    .trickle_enable_n_i        (trickle_enable_n_i),
    .up_i                      (up_i),
    .freeze_i                  (freeze),
    .data_i                    (data_i),
    .count_i                   (count),
    .op_o                      (op),
    .next_count_o              (next_count)
  );

  // No reset on purpose: the count powers up unknown, like the part
  always_ff @(posedge clk_i) begin
    count <= next_count;
  end

  assign count_o = count;

  // ----------------------------------------------------------------
  // Carry output
  // ----------------------------------------------------------------
  udc_carry u_carry (
    .trickle_enable_n_i (trickle_enable_n_i),
    .up_i               (up_i),
    .count_i            (count),
    .terminal_o         (terminal),
    .carry_out_n_o      (carry_n)
  );

  // Combinational on purpose: a registered carry would lag the enable
  // by a cycle and break single-clock cascading of stages
  assign carry_out_n_o = carry_n;

  // ----------------------------------------------------------------
  // Wrap event counter
  // ----------------------------------------------------------------
  assign wrap_event = terminal &&
                      (((op == udc_pkg::UDC_OP_UP)   &&  up_i) ||
                       ((op == udc_pkg::UDC_OP_DOWN) && !up_i));

  // A wrap in the clearing cycle is kept: the clear drops the old count and the counter restarts at one
  always_comb begin
    if (clr_wraps) begin
      next_wraps = wrap_event ? udc_pkg::WRAPS_ONE : udc_pkg::WRAPS_RST;
    end else if (wrap_event) begin
      next_wraps = wraps + udc_pkg::WRAPS_ONE;
    end else begin
      next_wraps = wraps;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wraps <= udc_pkg::WRAPS_RST;
    end else begin
      wraps <= next_wraps;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  assign wb_req       = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master sees ack
  assign wb_wr_commit = wb_req & wb_we_i & ack;
  assign hit_status   = (wb_adr_i == udc_pkg::REG_STATUS);
  assign hit_ctrl     = (wb_adr_i == udc_pkg::REG_CTRL);
  assign hit_wraps    = (wb_adr_i == udc_pkg::REG_WRAPS);
  assign wr_ctrl      = wb_wr_commit & hit_ctrl & wb_sel_i[0];
  assign wr_freeze_val = wb_dat_i[udc_pkg::CTRL_FREEZE_BIT];
  assign clr_wraps    = wb_wr_commit & hit_wraps;

  assign status_word = {23'h00_0000, freeze, 2'h0, up_i, carry_n, count};
  assign ctrl_word   = {31'h0000_0000, freeze};
  assign wraps_word  = {16'h0000, wraps};

  // Unmapped addresses still answer, with zero data and no effect
  assign rd_data = hit_status ? status_word :
                   hit_ctrl   ? ctrl_word   :
                   hit_wraps  ? wraps_word  : udc_pkg::RD_ZERO;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= wb_req & ~ack;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_q <= udc_pkg::RD_ZERO;
    end else if (wb_req & ~ack) begin
      rd_data_q <= rd_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freeze <= udc_pkg::CTRL_FREEZE_RST;
    end else if (wr_ctrl) begin
      freeze <= wr_freeze_val;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rd_data_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking chk_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_load_req;
    !load_n_i;
  endsequence

  sequence s_count_req;
    load_n_i && !count_enable_parallel_n_i && !trickle_enable_n_i && !freeze;
  endsequence

  sequence s_wb_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  chk_load_copies_data: assert property (
    s_load_req |=> (count_o == $past(data_i)))
    else $error("count did not take the load data");

  chk_hold_when_disabled: assert property (
    (load_n_i && (count_enable_parallel_n_i || trickle_enable_n_i))
    |=> $stable(count_o))
    else $error("count changed while counting was disabled");

  chk_count_up_step: assert property (
    (s_count_req ##0 up_i) |=> (count_o == 4'($past(count_o) + 4'h1)))
    else $error("count did not step up by one");

  chk_count_down_step: assert property (
    (s_count_req ##0 !up_i) |=> (count_o == 4'($past(count_o) - 4'h1)))
    else $error("count did not step down by one");

  chk_wrap_both_ways: assert property (
    (s_count_req ##0 ((up_i && count_o == 4'hF) || (!up_i && count_o == 4'h0)))
    |=> (count_o == (($past(up_i)) ? 4'h0 : 4'hF)))
    else $error("count did not wrap modulo sixteen");

  chk_carry_terminal: assert property (
    (!trickle_enable_n_i && up_i && count_o == 4'hF) |-> !carry_out_n_o)
    else $error("carry not low at terminal count");

  chk_carry_only_trickle: assert property (
    (trickle_enable_n_i || (up_i ? count_o != 4'hF : count_o != 4'h0))
    |-> carry_out_n_o)
    else $error("carry low without trickle enable and terminal count");

  chk_wb_single_ack: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> s_wb_answer)
    else $error("register answer not a single cycle");

  chk_freeze_holds: assert property (
    (freeze && load_n_i) |=> $stable(count_o))
    else $error("count moved while frozen");

  chk_carry_down_term: assert property (
    (!trickle_enable_n_i && !up_i && count_o == udc_pkg::CNT_MIN) |-> !carry_out_n_o)
    else $error("carry not low at zero counting down");

  chk_frozen_no_wrap: assert property (
    freeze |-> !wrap_event)
    else $error("wrap counted while frozen");

  // ----------------------------------------------------------------
  // Register port and wrap counter checks
  // ----------------------------------------------------------------
  // These watch the internal decode, so a broken address map shows up
  // here even when the bench reads back a register it did not mean to

  sequence s_wb_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_wrap_step;
    wrap_event && !clr_wraps;
  endsequence

  chk_ack_one_cycle: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack stood for more than one cycle");

  chk_ack_only_req: assert property (
    (!wb_cyc_i || !wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");

  chk_freeze_write: assert property (
    wr_ctrl |=> (freeze == $past(wr_freeze_val)))
    else $error("freeze bit did not take the write");

  chk_ctrl_readback: assert property (
    (s_wb_take ##0 hit_ctrl) |=> (wb_dat_o == {31'h0000_0000, $past(freeze)}))
    else $error("control read data wrong");

  chk_status_count: assert property (
    (s_wb_take ##0 hit_status)
    |=> (wb_dat_o[udc_pkg::STAT_COUNT_LSB +: udc_pkg::CNT_W] == $past(count_o)))
    else $error("status read lost the count");

  chk_unmapped_zero: assert property (
    (s_wb_take ##0 (!hit_status && !hit_ctrl && !hit_wraps))
    |=> (wb_dat_o == udc_pkg::RD_ZERO))
    else $error("unmapped read not zero");

  chk_wraps_step: assert property (
    s_wrap_step |=> (wraps == 16'($past(wraps) + udc_pkg::WRAPS_ONE)))
    else $error("wrap counter did not step");

  chk_wraps_hold: assert property (
    (!wrap_event && !clr_wraps) |=> $stable(wraps))
    else $error("wrap counter moved without a wrap");

  chk_wraps_no_load: assert property (
    (s_load_req ##0 !clr_wraps) |=> $stable(wraps))
    else $error("a load was counted as a wrap");

  chk_wraps_clear: assert property (
    clr_wraps
    |=> (wraps == ($past(wrap_event) ? udc_pkg::WRAPS_ONE : udc_pkg::WRAPS_RST)))
    else $error("wrap counter clear wrong");

endmodule

// *** dv/udc_stage_model.sv ***
/*
  Behavioural next stage of a counter cascade, fed by the low-going carry.
  Assumes it shares clk_i with the counter under test and is cleared first.
*/
`timescale 1ns/1ns
module udc_stage_model (
  input  wire logic                        clk_i,
  input  wire logic                        load_n_i,
  input  wire logic                        carry_n_i,
  output logic      [udc_pkg::CNT_W-1:0]   count_o
);
  // ----------------------------------------------------------------
  // Upper stage
  // ----------------------------------------------------------------
  // Advances only while the lower stage shows its terminal count
  always_ff @(posedge clk_i) begin
    if (!load_n_i) begin
      count_o <= udc_pkg::CNT_MIN;
    end else if (!carry_n_i) begin
      count_o <= count_o + udc_pkg::CNT_ONE;
    end
  end
endmodule

// *** dv/udc_counter_tb.sv ***
/*
  Self-checking bench of the 4-bit up/down counter and its register port.
  Assumes a classic Wishbone slave that acks once per request.
*/
`timescale 1ns/1ns
module udc_counter_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  // Loads during reset, so the unreset count is known once checks start
  logic        load_n = 1'b0;
  logic [3:0]  data = 4'h0;
  logic        par_en_n = 1'b1;
  logic        trk_en_n = 1'b1;
  logic        up_dir = 1'b1;
  logic        div_mode = 1'b0;
  logic        up_ld_n = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        wbwe = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [3:0]  count_o;
  logic [3:0]  up_cnt;
  logic        carry_out_n_o;
  int          error_cnt = 0;
  int          tests_run = 0;

  always #2 clk_i = ~clk_i;

  udc_counter dut (.clk_i(clk_i), .rst_i(rst_i),
    .load_n_i(div_mode ? carry_out_n_o : load_n),
    .data_i(data), .count_enable_parallel_n_i(par_en_n), .trickle_enable_n_i(trk_en_n),
    .up_i(up_dir), .count_o(count_o), .carry_out_n_o(carry_out_n_o),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wbwe), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  udc_stage_model upper (.clk_i(clk_i), .load_n_i(up_ld_n), .carry_n_i(carry_out_n_o),
    .count_o(up_cnt));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Drives the pins for the next edge, then checks state left by the last edge
  task automatic step(input logic ld, input logic [3:0] d, input logic cep, input logic cet,
                      input logic up, input bit chk, input logic [3:0] ec, input logic ecar);
    load_n   <= ld;
    data     <= d;
    par_en_n <= cep;
    trk_en_n <= cet;
    up_dir <= up;
    @(negedge clk_i);
    if (chk) begin
      check(32'(count_o), 32'(ec), "count");
      check(32'(carry_out_n_o), 32'(ecar), "carry");
    end
    @(posedge clk_i);
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd,
                    output logic [31:0] rd);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    wbwe <= we;
    adr  <= a;
    wdat <= wd;
    // Waits as long as it takes; only the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    wb(1'b0, a, 32'h0000_0000, r);
    check(r, exp, what);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_walk;
    step(1'b0, 4'hD, 1'b1, 1'b1, 1'b1, 0, 4'h0, 1'b1);
    step(1'b1, 4'h0, 1'b0, 1'b0, 1'b1, 1, 4'hD, 1'b1);
    step(1'b1, 4'h0, 1'b0, 1'b0, 1'b1, 1, 4'hE, 1'b1);
    step(1'b1, 4'h0, 1'b0, 1'b0, 1'b1, 1, 4'hF, 1'b0);
    step(1'b1, 4'h0, 1'b1, 1'b1, 1'b1, 1, 4'h0, 1'b1);
    step(1'b1, 4'h0, 1'b0, 1'b0, 1'b0, 1, 4'h0, 1'b0);
    step(1'b0, 4'h5, 1'b0, 1'b0, 1'b0, 1, 4'hF, 1'b1);
    step(1'b1, 4'h0, 1'b0, 1'b1, 1'b1, 1, 4'h5, 1'b1);
    step(1'b1, 4'h0, 1'b1, 1'b0, 1'b1, 1, 4'h5, 1'b1);
    step(1'b0, 4'hF, 1'b1, 1'b0, 1'b1, 1, 4'h5, 1'b1);
    step(1'b1, 4'h0, 1'b1, 1'b0, 1'b1, 1, 4'hF, 1'b0);
    step(1'b1, 4'h0, 1'b1, 1'b0, 1'b0, 1, 4'hF, 1'b1);
    step(1'b1, 4'h0, 1'b1, 1'b1, 1'b1, 1, 4'hF, 1'b1);
  endtask

  task automatic t_load_all;
    for (int v = 0; v <= 16; v++) begin
      step(v == 16, 4'(v), 1'b1, 1'b1, 1'b1, v > 0, 4'(v - 1), 1'b1);
    end
  endtask

  task automatic t_regs;
    logic [31:0] r;
    rd_chk(udc_pkg::REG_WRAPS, 32'h0000_0002, "wraps");
    rd_chk(udc_pkg::REG_STATUS, 32'h0000_003F, "status");
    wb(1'b1, udc_pkg::REG_CTRL, 32'h0000_0001, r);
    rd_chk(udc_pkg::REG_STATUS, 32'h0000_013F, "status frozen");
    step(1'b1, 4'h0, 1'b0, 1'b0, 1'b1, 1, 4'hF, 1'b0);
    step(1'b0, 4'h3, 1'b0, 1'b0, 1'b1, 1, 4'hF, 1'b0);
    step(1'b1, 4'h0, 1'b1, 1'b1, 1'b1, 1, 4'h3, 1'b1);
    wb(1'b1, udc_pkg::REG_CTRL, 32'h0000_0000, r);
    rd_chk(udc_pkg::REG_CTRL, 32'h0000_0000, "ctrl");
    sel <= 4'hE;
    wb(1'b1, udc_pkg::REG_CTRL, 32'h0000_0001, r);
    sel <= 4'hF;
    rd_chk(udc_pkg::REG_CTRL, 32'h0000_0000, "ctrl lane masked");
    wb(1'b1, 8'h0C, 32'h0000_0001, r);
    rd_chk(8'h0C, 32'h0000_0000, "unmapped");
    wb(1'b1, udc_pkg::REG_WRAPS, 32'h0000_0000, r);
    rd_chk(udc_pkg::REG_WRAPS, 32'h0000_0000, "wraps cleared");
  endtask

  task automatic t_cascade;
    up_ld_n <= 1'b0;
    step(1'b0, 4'hE, 1'b1, 1'b1, 1'b1, 0, 4'h0, 1'b1);
    up_ld_n <= 1'b1;
    step(1'b1, 4'h0, 1'b0, 1'b0, 1'b1, 1, 4'hE, 1'b1);
    step(1'b1, 4'h0, 1'b0, 1'b0, 1'b1, 1, 4'hF, 1'b0);
    step(1'b0, 4'hE, 1'b1, 1'b1, 1'b1, 1, 4'h0, 1'b1);
    check(32'(up_cnt), 32'h0000_0001, "upper stage");
    div_mode <= 1'b1;
    step(1'b1, 4'hC, 1'b0, 1'b0, 1'b1, 1, 4'hE, 1'b1);
    step(1'b1, 4'hC, 1'b0, 1'b0, 1'b1, 1, 4'hF, 1'b0);
    div_mode <= 1'b0;
    step(1'b1, 4'hC, 1'b1, 1'b1, 1'b1, 1, 4'hC, 1'b1);
    check(32'(up_cnt), 32'h0000_0002, "upper stage");
    rd_chk(udc_pkg::REG_WRAPS, 32'h0000_0001, "wraps");
  endtask

  // Reset in mid-run clears the register port but must leave the count
  task automatic t_reset;
    logic [31:0] r;
    wb(1'b1, udc_pkg::REG_CTRL, 32'h0000_0001, r);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    step(1'b1, 4'h0, 1'b1, 1'b1, 1'b1, 1, 4'hC, 1'b1);
    rd_chk(udc_pkg::REG_CTRL, 32'h0000_0000, "ctrl after reset");
    rd_chk(udc_pkg::REG_WRAPS, 32'h0000_0000, "wraps after reset");
  endtask

  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(udc_pkg::REG_CTRL, 32'h0000_0000, "ctrl reset");
    rd_chk(udc_pkg::REG_WRAPS, 32'h0000_0000, "wraps reset");
    t_walk();
    t_load_all();
    t_regs();
    t_cascade();
    t_reset();
    results();
  end

  // Whole run needs well under 400 cycles
  initial begin
    #20000;
    error_cnt++;
    results();
  end
endmodule
